// ### logic/otc_oscillator_trim_calibrator.sv
// oscillator trim calibrator with wishbone register slave
//
// Contract
// - accept oscillator only within 0.1 percent
// - step trim when count leaves window
// - repeat until inside window, then hold; code also stops with the limit flag set once trim is at its end
// - select input picks subsystem or external
// - start on falling edge of switch
// - counter counts undivided fast oscillator
// - 16-bit captures triggered by reference
// - subsystem reference measured four times
// - external pin routed through event link
// - 10 ms debounce on start switch
// - clock output is main clock over 16
// - subsystem sum window 3903 to 3909
// - external low width window 62438 to 62561
// - slow steps trim up, fast down
// - external mode measures low-level width
`timescale 1ns/1ps
module otc_oscillator_trim_calibrator #(
  parameter int          TRIM_W     = 6,
  parameter int          TRIM_RESET = 32,
  parameter int          DEB_TICKS  = otc_pkg::OTC_DEB_TICKS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              fast_osc_count_clock_i,
  input  wire logic              subsystem_clock_i,
  input  wire logic              external_reference_pin_i,
  input  wire logic              ref_select_i,
  input  wire logic              start_switch_n_i,
  output logic      [TRIM_W-1:0] oscillator_trim_value_o,
  output logic                   clock_output_pin_o,
  output logic                   cal_busy_o,
  output logic                   cal_done_o
);
  import otc_pkg::*;

  localparam int DEB_W = $clog2(DEB_TICKS + 1);
  localparam logic [TRIM_W-1:0] TRIM_MAX = {TRIM_W{1'b1}};
  localparam logic [TRIM_W-1:0] TRIM_MIN = '0;
  localparam logic [TRIM_W-1:0] TRIM_RST = TRIM_W'(TRIM_RESET);
  localparam logic [DEB_W-1:0]  DEB_LAST = DEB_W'(DEB_TICKS - 1);

  initial begin
    if (TRIM_W < 2 || TRIM_W > 16) $error("TRIM_W out of range");
    if (TRIM_RESET < 0 || TRIM_RESET >= (1 << TRIM_W)) $error("TRIM_RESET out of range");
    if (DEB_TICKS < 1) $error("DEB_TICKS must be positive");
  end

  // register state
  otc_state_e              state, next_state;
  logic [TRIM_W-1:0]       trim, next_trim;
  logic [OTC_CAP_W-1:0]    cnt, next_cnt;
  logic [OTC_SUM_W-1:0]    sum, next_sum;
  logic [OTC_SUM_W-1:0]    last_count, next_last_count;
  logic [2:0]              cap_idx, next_cap_idx;
  logic                    mode_ext, next_mode_ext;
  logic                    done, next_done;
  logic                    limit, next_limit;
  logic                    win_lo, next_win_lo;
  logic                    win_hi, next_win_hi;
  logic                    sub_q, next_sub_q;
  logic                    evl_q, next_evl_q;
  logic                    sw_stable, next_sw_stable;
  logic [DEB_W-1:0]        deb_cnt, next_deb_cnt;
  logic [2:0]              div_cnt, next_div_cnt;
  logic                    clk_out, next_clk_out;
  logic                    ack, next_ack;
  logic [31:0]             rdata, next_rdata;

  // event link: input selector 0 feeds L1 in pass-through, output selector 7 to capture
  logic [OTC_EVL_OUTS-1:0] evl_out;
  logic                    evl_l1;
  logic                    capture_src;
  assign evl_l1 = (OTC_EVL_IN_SEL == 0) ? external_reference_pin_i : 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < OTC_EVL_OUTS; gi++) begin : g_evl
      assign evl_out[gi] = (gi == OTC_EVL_OUT_SEL) ? evl_l1 : 1'b0;
    end
  endgenerate
  assign capture_src = evl_out[OTC_EVL_OUT_SEL];

  // edge events
  logic sub_rise;
  logic evl_fall;
  logic evl_rise;
  logic sw_press;
  logic wb_req;
  logic wb_wr;
  logic sw_start;
  logic sw_abort;
  logic start_req;
  logic in_win;
  logic is_slow;
  logic [OTC_SUM_W-1:0] meas_val;
  logic [OTC_SUM_W-1:0] win_lo_v;
  logic [OTC_SUM_W-1:0] win_hi_v;

  assign sub_rise = subsystem_clock_i & ~sub_q;
  assign evl_fall = ~capture_src & evl_q;
  assign evl_rise = capture_src & ~evl_q;
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack;
  assign wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  assign sw_start = wb_wr && (wb_adr_i == OTC_ADDR_CTRL) && wb_dat_i[OTC_CTRL_START_BIT];
  assign sw_abort = wb_wr && (wb_adr_i == OTC_ADDR_CTRL) && wb_dat_i[OTC_CTRL_ABORT_BIT];

  always_comb begin
    next_sw_stable = sw_stable;
    next_deb_cnt   = deb_cnt;
    sw_press       = 1'b0;
    if (start_switch_n_i == sw_stable) begin
      next_deb_cnt = '0;
    end else if (sub_rise) begin
      if (deb_cnt == DEB_LAST) begin
        next_deb_cnt   = '0;
        next_sw_stable = start_switch_n_i;
        sw_press       = ~start_switch_n_i;
      end else begin
        next_deb_cnt = deb_cnt + 1'b1;
      end
    end
  end

  assign start_req = sw_press | sw_start;

  assign win_lo_v = mode_ext ? OTC_EXT_LO : OTC_SUB_LO;
  assign win_hi_v = mode_ext ? OTC_EXT_HI : OTC_SUB_HI;
  assign meas_val = sum;
  assign in_win   = (meas_val >= win_lo_v) && (meas_val <= win_hi_v);
  assign is_slow  = meas_val < win_lo_v;

  always_comb begin
    next_state      = state;
    next_trim       = trim;
    next_cnt        = cnt;
    next_sum        = sum;
    next_last_count = last_count;
    next_cap_idx    = cap_idx;
    next_mode_ext   = mode_ext;
    next_done       = done;
    next_limit      = limit;
    next_win_lo     = win_lo;
    next_win_hi     = win_hi;
    next_sub_q      = subsystem_clock_i;
    next_evl_q      = capture_src;
    // count on every fast oscillator cycle
    if (fast_osc_count_clock_i) begin
      next_cnt = cnt + 1'b1;
    end
    case (state)
      OTC_IDLE, OTC_DONE: begin
        if (start_req) begin
          next_mode_ext = ref_select_i;
          next_done     = 1'b0;
          next_limit    = 1'b0;
          next_state    = OTC_ARM;
        end
      end
      OTC_ARM: begin
        next_sum     = '0;
        next_cap_idx = '0;
        // external: width starts at falling edge
        if ((mode_ext && evl_fall) || (!mode_ext && sub_rise)) begin
          next_cnt   = OTC_CAP_W'(fast_osc_count_clock_i);
          next_state = OTC_MEAS;
        end
      end
      OTC_MEAS: begin
        if (mode_ext && evl_rise) begin
          next_sum   = OTC_SUM_W'(cnt);
          next_state = OTC_EVAL;
        end else if (!mode_ext && sub_rise) begin
          next_sum = sum + OTC_SUM_W'(cnt);
          // restart with this cycle's pulse so no fast cycle is lost at a capture
          next_cnt = OTC_CAP_W'(fast_osc_count_clock_i);
          if (cap_idx == OTC_SUB_CAP_LAST) begin
            next_state = OTC_EVAL;
          end else begin
            next_cap_idx = cap_idx + 1'b1;
          end
        end
      end
      OTC_EVAL: begin
        next_last_count = sum;
        next_win_lo     = is_slow;
        next_win_hi     = !in_win && !is_slow;
        if (in_win) begin
          next_done  = 1'b1;
          next_state = OTC_DONE;
        end else if (is_slow) begin
          if (trim == TRIM_MAX) begin
            next_limit = 1'b1;
            next_state = OTC_DONE;
          end else begin
            next_trim  = trim + 1'b1;
            next_state = OTC_ARM;
          end
        end else begin
          if (trim == TRIM_MIN) begin
            next_limit = 1'b1;
            next_state = OTC_DONE;
          end else begin
            next_trim  = trim - 1'b1;
            next_state = OTC_ARM;
          end
        end
      end
      default: begin
        next_state = OTC_IDLE;
      end
    endcase
    if (sw_abort && state != OTC_IDLE && state != OTC_DONE) begin
      next_state = OTC_IDLE;
    end
    // software may preload the trim only while idle or done
    if (wb_wr && wb_adr_i == OTC_ADDR_TRIM && (state == OTC_IDLE || state == OTC_DONE) && !start_req) begin
      next_trim = wb_dat_i[TRIM_W-1:0];
    end
  end

  always_comb begin
    next_div_cnt = div_cnt + 1'b1;
    next_clk_out = clk_out;
    if (div_cnt == 3'(OTC_CLKOUT_HALF - 1)) begin
      next_div_cnt = '0;
      next_clk_out = ~clk_out;
    end
  end

  // wishbone classic slave, one wait state, unmapped reads zero
  always_comb begin
    next_ack   = wb_req;
    next_rdata = rdata;
    if (wb_req) begin
      next_rdata = OTC_RST_WORD;
      case (wb_adr_i)
        OTC_ADDR_CTRL: begin
          next_rdata = OTC_RST_WORD;
        end
        OTC_ADDR_STATUS: begin
          next_rdata[OTC_STAT_BUSY_BIT]   = (state != OTC_IDLE) && (state != OTC_DONE);
          next_rdata[OTC_STAT_DONE_BIT]   = done;
          next_rdata[OTC_STAT_LIMIT_BIT]  = limit;
          next_rdata[OTC_STAT_REFSEL_BIT] = mode_ext;
          next_rdata[OTC_STAT_SW_BIT]     = sw_stable;
        end
        OTC_ADDR_TRIM: begin
          next_rdata[TRIM_W-1:0] = trim;
        end
        OTC_ADDR_COUNT: begin
          next_rdata[OTC_SUM_W-1:0] = last_count;
        end
        OTC_ADDR_WIN: begin
          next_rdata[OTC_WIN_LO_BIT] = win_lo;
          next_rdata[OTC_WIN_HI_BIT] = win_hi;
        end
        default: begin
          next_rdata = OTC_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= OTC_IDLE;
      trim       <= TRIM_RST;
      cnt        <= '0;
      sum        <= '0;
      last_count <= '0;
      cap_idx    <= '0;
      mode_ext   <= 1'b0;
      done       <= 1'b0;
      limit      <= 1'b0;
      win_lo     <= 1'b0;
      win_hi     <= 1'b0;
      sub_q      <= 1'b0;
      evl_q      <= 1'b0;
      sw_stable  <= 1'b1;
      deb_cnt    <= '0;
      div_cnt    <= '0;
      clk_out    <= 1'b0;
      ack        <= 1'b0;
      rdata      <= OTC_RST_WORD;
    end else begin
      state      <= next_state;
      trim       <= next_trim;
      cnt        <= next_cnt;
      sum        <= next_sum;
      last_count <= next_last_count;
      cap_idx    <= next_cap_idx;
      mode_ext   <= next_mode_ext;
      done       <= next_done;
      limit      <= next_limit;
      win_lo     <= next_win_lo;
      win_hi     <= next_win_hi;
      sub_q      <= next_sub_q;
      evl_q      <= next_evl_q;
      sw_stable  <= next_sw_stable;
      deb_cnt    <= next_deb_cnt;
      div_cnt    <= next_div_cnt;
      clk_out    <= next_clk_out;
      ack        <= next_ack;
      rdata      <= next_rdata;
    end
  end

  // busy and done outputs registered alongside state
  logic busy_q;
  logic next_busy;
  assign next_busy = (next_state != OTC_IDLE) && (next_state != OTC_DONE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= next_busy;
    end
  end

  assign oscillator_trim_value_o = trim;
  assign clock_output_pin_o      = clk_out;
  assign cal_busy_o              = busy_q;
  assign cal_done_o              = done;
  assign wb_ack_o                = ack;
  assign wb_dat_o                = rdata;

endmodule : otc_oscillator_trim_calibrator

// ### logic/otc_pkg.sv
// shared constants of the oscillator trim calibrator
package otc_pkg;
  // register byte addresses
  localparam logic [7:0] OTC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] OTC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] OTC_ADDR_TRIM   = 8'h08;
  localparam logic [7:0] OTC_ADDR_COUNT  = 8'h0c;
  localparam logic [7:0] OTC_ADDR_WIN    = 8'h10;
  // control fields
  localparam int OTC_CTRL_START_BIT  = 0;
  localparam int OTC_CTRL_ABORT_BIT  = 1;
  // status fields
  localparam int OTC_STAT_BUSY_BIT   = 0;
  localparam int OTC_STAT_DONE_BIT   = 1;
  localparam int OTC_STAT_LIMIT_BIT  = 2;
  localparam int OTC_STAT_REFSEL_BIT = 3;
  localparam int OTC_STAT_SW_BIT     = 4;
  // window field of the window register
  localparam int OTC_WIN_LO_BIT      = 0;
  localparam int OTC_WIN_HI_BIT      = 1;
  // reset values
  localparam logic [31:0] OTC_RST_WORD = 32'h0000_0000;
  // measurement sizes
  localparam int OTC_CAP_W   = 16;
  localparam int OTC_SUM_W   = 18;
  localparam int OTC_SUB_CAPTURES = 4;
  localparam logic [2:0] OTC_SUB_CAP_LAST = 3'h3;
  // acceptance windows, subsystem reference: sum of four intervals
  localparam logic [OTC_SUM_W-1:0] OTC_SUB_LO = 18'd3903;
  localparam logic [OTC_SUM_W-1:0] OTC_SUB_HI = 18'd3909;
  // acceptance windows, external reference: low width
  localparam logic [OTC_SUM_W-1:0] OTC_EXT_LO = 18'd62438;
  localparam logic [OTC_SUM_W-1:0] OTC_EXT_HI = 18'd62561;
  // event link routing of the external reference
  localparam int OTC_EVL_IN_SEL  = 0;
  localparam int OTC_EVL_OUT_SEL = 7;
  localparam int OTC_EVL_OUTS    = 8;
  // debounce interval on the subsystem clock
  localparam longint OTC_DEB_TIME_US = 10000;
  localparam longint OTC_SUB_HZ      = 32768;
  localparam int OTC_DEB_TICKS = int'((OTC_DEB_TIME_US * OTC_SUB_HZ + 64'd999999) / 64'd1000000);
  // clock output divider
  localparam int OTC_CLK_HZ     = 20000000;
  localparam int OTC_CLKOUT_DIV = 16;
  localparam int OTC_CLKOUT_HALF = OTC_CLKOUT_DIV / 2;
  // state machine
  typedef enum logic [2:0] {
    OTC_IDLE,
    OTC_ARM,
    OTC_MEAS,
    OTC_EVAL,
    OTC_DONE
  } otc_state_e;
endpackage : otc_pkg

// ### test/otc_calibrator_chk.sv
// port assertions for the oscillator trim calibrator
`timescale 1ns/1ps
module otc_calibrator_chk
  import otc_pkg::*;
#(parameter int TRIM_W = 6) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              start_switch_n_i,
  input wire logic [TRIM_W-1:0] oscillator_trim_value_o,
  input wire logic              clock_output_pin_o,
  input wire logic              cal_busy_o,
  input wire logic              cal_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  a_clkout_half: assert property (
    $rose(clock_output_pin_o) |-> clock_output_pin_o [*8] ##1 !clock_output_pin_o) else $error("clock out period");
  a_trim_unit_step: assert property (
    !$stable(oscillator_trim_value_o) && $past(cal_busy_o) |-> oscillator_trim_value_o == $past(
    oscillator_trim_value_o) + 32'h1 || oscillator_trim_value_o == $past(oscillator_trim_value_o) - 32'h1)
    else $error("trim step not one");
  a_done_no_step: assert property (
    cal_done_o && !(wb_cyc_i && wb_we_i) |=> $stable(oscillator_trim_value_o)) else $error("trim moved");
  a_step_only_busy: assert property (
    !$stable(oscillator_trim_value_o) && !$past(cal_busy_o) |-> $past(wb_cyc_i && wb_we_i))
    else $error("trim moved while idle");
  a_done_idle: assert property (cal_done_o |-> !cal_busy_o) else $error("done while busy");
  a_done_after_busy: assert property ($rose(cal_done_o) |-> $past(cal_busy_o)) else $error("done early");
  a_done_sticky: assert property (
    cal_done_o && !req && start_switch_n_i |=> cal_done_o) else $error("done lost");
  a_start_busy: assert property (
    req && wb_we_i && wb_adr_i == OTC_ADDR_CTRL && wb_dat_i[OTC_CTRL_START_BIT] && !wb_dat_i[OTC_CTRL_ABORT_BIT]
    && !cal_busy_o |-> ##[1:2] cal_busy_o) else $error("start not taken");
endmodule : otc_calibrator_chk
bind otc_oscillator_trim_calibrator otc_calibrator_chk #(.TRIM_W(TRIM_W)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .start_switch_n_i(start_switch_n_i),
  .oscillator_trim_value_o(oscillator_trim_value_o), .clock_output_pin_o(clock_output_pin_o),
  .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o));

// ### test/otc_osc_ref_model.sv
// trimmed fast oscillator and time-scaled reference sources
`timescale 1ns/1ps
module otc_osc_ref_model #(
  parameter int TRIM_W = 3
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [TRIM_W-1:0] trim_i,
  input  wire logic [9:0]        base_step_i,
  input  wire logic              ext_run_i,
  output logic                   fast_en_o,
  output logic                   sub_clk_o,
  output logic                   ext_pin_o
);
  logic [10:0] acc;
  logic [10:0] next_acc;
  logic [9:0]  sub_cnt;
  logic [9:0]  next_sub_cnt;
  logic [16:0] ext_cnt;
  logic [16:0] next_ext_cnt;
  logic [16:0] ext_phase;
  always_comb begin
    // rate is (base + trim) counts per 1024 clocks, so one trim step moves it by one
    next_acc     = {1'b0, acc[9:0]} + 11'(base_step_i) + 11'(trim_i);
    next_sub_cnt = sub_cnt + 10'h1;
    next_ext_cnt = ext_run_i ? ext_cnt + 17'h1 : 17'h0;
  end
  always_ff @(posedge clk_i) begin
    acc     <= rst_i ? 11'h0 : next_acc;
    sub_cnt <= rst_i ? 10'h0 : next_sub_cnt;
    ext_cnt <= rst_i ? 17'h0 : next_ext_cnt;
  end
  assign fast_en_o = acc[10];
  // subsystem period scaled to 1024 clocks
  assign sub_clk_o = sub_cnt[9];
  assign ext_phase = ext_cnt - 17'h10;
  // square wave, equal halves of 65536 clocks
  assign ext_pin_o = !ext_run_i || ext_phase[16];
endmodule : otc_osc_ref_model

// ### test/otc_oscillator_trim_calibrator_tb_top.sv
// self-checking bench for the oscillator trim calibrator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module otc_oscillator_trim_calibrator_tb_top;
  import otc_pkg::*;
  localparam int TW = 3;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          cyc = 1'b0;
  logic          stb = 1'b0;
  logic          we = 1'b0;
  logic [7:0]    adr = 8'h00;
  logic [31:0]   wdat = 32'h0;
  logic [31:0]   rdat;
  logic          ack;
  logic          fast_en;
  logic          sub_clk;
  logic          ext_pin;
  logic          ref_sel = 1'b0;
  logic          sw_n = 1'b1;
  logic [TW-1:0] trim;
  logic          busy;
  logic          done;
  logic [9:0]    base = 10'd972;
  logic          ext_run = 1'b0;
  logic [31:0]   rd;
  int            bad_count = 0;
  int            check_count = 0;
  always #25 clk_i = ~clk_i;
  otc_oscillator_trim_calibrator #(.TRIM_W(TW), .TRIM_RESET(4), .DEB_TICKS(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fast_osc_count_clock_i(fast_en),
    .subsystem_clock_i(sub_clk), .external_reference_pin_i(ext_pin), .ref_select_i(ref_sel),
    .start_switch_n_i(sw_n), .oscillator_trim_value_o(trim), .clock_output_pin_o(),
    .cal_busy_o(busy), .cal_done_o(done));
  otc_osc_ref_model #(.TRIM_W(TW)) i_model (.clk_i(clk_i), .rst_i(rst_i), .trim_i(trim), .base_step_i(base),
    .ext_run_i(ext_run), .fast_en_o(fast_en), .sub_clk_o(sub_clk), .ext_pin_o(ext_pin));
  task automatic wb_op(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    while (ack !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) begin
      bad_count++;
      $display("[FAIL] ack expected 1 seen %b", ack);
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb_op
  task automatic wait_cal();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("busy_rise", 1'b1, busy)
    while (busy !== 1'b0 && n < 90000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("busy_fall", 1'b0, busy)
  endtask : wait_cal
  task automatic finish_test(input string nm, input logic [TW-1:0] tr, input logic [31:0] st, win, lo, hi);
    wb_op(1'b0, OTC_ADDR_STATUS, 32'h0);
    `CHK("status", st, rd)
    `CHK("done_pin", st[OTC_STAT_DONE_BIT], done)
    wb_op(1'b0, OTC_ADDR_WIN, 32'h0);
    `CHK("window", win, rd)
    wb_op(1'b0, OTC_ADDR_COUNT, 32'h0);
    `CHK("count", 1'b1, rd >= lo && rd <= hi)
    wb_op(1'b0, OTC_ADDR_TRIM, 32'h0);
    `CHK("trim", tr, rd[TW-1:0])
    $display("test %s ended", nm);
  endtask : finish_test
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (99000) @(posedge clk_i);
    bad_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_op(1'b0, OTC_ADDR_STATUS, 32'h0);
    `CHK("status_rst", 32'h10, rd)
    wb_op(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb_op(1'b0, OTC_ADDR_TRIM, 32'h0);
    `CHK("trim_rst", 32'h4, rd)
    base <= 10'd971;
    sw_n <= 1'b0;
    wait_cal();
    sw_n <= 1'b1;
    finish_test("switch_slow", 3'h5, 32'h02, 32'h0, 32'd3903, 32'd3909);
    wb_op(1'b1, OTC_ADDR_TRIM, 32'h4);
    base <= 10'd974;
    wb_op(1'b1, OTC_ADDR_CTRL, 32'h1);
    wait_cal();
    finish_test("ctrl_fast", 3'h3, 32'h12, 32'h0, 32'd3903, 32'd3909);
    wb_op(1'b1, OTC_ADDR_TRIM, 32'h7);
    base <= 10'd960;
    wb_op(1'b1, OTC_ADDR_CTRL, 32'h1);
    wait_cal();
    finish_test("limit", 3'h7, 32'h14, 32'h1, 32'd0, 32'd3902);
    wb_op(1'b1, OTC_ADDR_CTRL, 32'h1);
    wb_op(1'b1, OTC_ADDR_CTRL, 32'h2);
    finish_test("abort", 3'h7, 32'h10, 32'h1, 32'd0, 32'd3902);
    wb_op(1'b1, OTC_ADDR_TRIM, 32'h4);
    base <= 10'd972;
    ref_sel <= 1'b1;
    ext_run <= 1'b1;
    wb_op(1'b1, OTC_ADDR_CTRL, 32'h1);
    wb_op(1'b1, OTC_ADDR_TRIM, 32'h0);
    wait_cal();
    finish_test("ext_width", 3'h4, 32'h1a, 32'h0, 32'd62438, 32'd62561);
    close_out();
  end
endmodule : otc_oscillator_trim_calibrator_tb_top
